// [hdl/pmc_pkg.sv]
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_MODE_ACTIVE,
    PMC_MODE_ALT_ACTIVE,
    PMC_MODE_SLEEP,
    PMC_MODE_HIBERNATE
  } pmc_mode_t;

  localparam int          PMC_SUBSYS_W      = 8;
  localparam int          PMC_CPU_BIT       = 0;
  localparam int          PMC_FLASH_BIT     = 1;
  localparam int          PMC_CLK_MHZ       = 100;
  localparam int          PMC_RESUME_US     = 15;
  localparam int          PMC_RESUME_CYC    = PMC_RESUME_US * PMC_CLK_MHZ;
  localparam int          PMC_CNT_W         = 11;
  localparam logic [7:0]  PMC_ACT_TPL_RST   = 8'hff;
  localparam logic [7:0]  PMC_ALT_TPL_RST   = 8'hfc;
  localparam logic [7:0]  PMC_SLEEP_KEEP    = 8'h00;
  localparam logic [1:0]  PMC_REQ_ALT       = 2'h1;
  localparam logic [1:0]  PMC_REQ_SLEEP     = 2'h2;
  localparam logic [1:0]  PMC_REQ_HIB       = 2'h3;
  localparam logic [1:0]  PMC_SLPCLK_LSO    = 2'h1;
  localparam logic [1:0]  PMC_SLPCLK_XTAL   = 2'h2;
endpackage

// [hdl/pmc_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Four modes: active, alt active, sleep, hibernate
// - Separate templates for active and alt active
// - Active template gates clocks of disabled resources
// - Template changes apply immediately while running
// - CPU may stop itself; wakeup restarts it
// - Wakeup forces active mode and CPU on
// - Active mode after reset
// - Alt active uses its own smaller template
// - Sleep disables most; timewheel and RTC stay
// - Sleep: write entry, buzzed regulators, slow clocks
// - Leaving sleep waits 15 us resume
// - Hibernate stops clocks; only pin wakeup
// - Hibernate leaves only hibernate regulator on
// - Internal regulators on after power-up
// - Hibernate exit only by pin interrupt
module pmc_top
  import pmc_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    clk_en,
  input  wire logic [PMC_SUBSYS_W-1:0] act_tpl_wdata,
  input  wire logic                    act_tpl_we,
  input  wire logic [PMC_SUBSYS_W-1:0] alt_tpl_wdata,
  input  wire logic                    alt_tpl_we,
  input  wire logic [1:0]              mode_req,
  input  wire logic                    mode_req_we,
  input  wire logic                    cpu_halt_req,
  input  wire logic                    slp_clk_xtal_sel,
  input  wire logic                    reg_disable,
  input  wire logic                    reg_disable_we,
  input  wire logic                    wk_comparator,
  input  wire logic                    wk_pin_interrupt_unit,
  input  wire logic                    wk_i2c,
  input  wire logic                    wk_rtc,
  input  wire logic                    wk_central_timewheel,
  input  wire logic                    wk_low_voltage_detect,
  input  wire logic                    wk_irq,
  output logic      [PMC_SUBSYS_W-1:0] subsys_clk_en,
  output logic                         cpu_en,
  output logic      [1:0]              mode_out,
  output logic                         sys_clk_run,
  output logic      [1:0]              slp_clk_sel,
  output logic                         timewheel_rtc_en,
  output logic                         dig_reg_en,
  output logic                         ana_reg_en,
  output logic                         reg_buzz,
  output logic                         hib_reg_en,
  output logic                         resuming,
  output logic      [PMC_SUBSYS_W-1:0] act_tpl_rd,
  output logic      [PMC_SUBSYS_W-1:0] alt_tpl_rd
);

  localparam logic [PMC_CNT_W-1:0] RESUME_LAST = PMC_CNT_W'(PMC_RESUME_CYC - 1);

  logic                    rst_s1_reg;
  logic                    rst_s2_reg;
  logic [6:0]              wk_s1_reg;
  logic [6:0]              wk_s2_reg;
  logic [6:0]              wk_raw;
  pmc_mode_t               mode_reg;
  pmc_mode_t               mode_next;
  logic [PMC_SUBSYS_W-1:0] act_tpl_reg;
  logic [PMC_SUBSYS_W-1:0] alt_tpl_reg;
  logic                    cpu_off_reg;
  logic                    cpu_off_next;
  logic                    ext_reg_off_reg;
  logic                    resume_reg;
  logic                    resume_next;
  logic [PMC_CNT_W-1:0]    resume_cnt_reg;
  logic [PMC_CNT_W-1:0]    resume_cnt_next;
  logic                    any_wake;
  logic                    sleep_wake;
  logic                    hib_wake;
  logic                    wake_evt;
  logic [PMC_SUBSYS_W-1:0] tpl_sel;
  logic [PMC_SUBSYS_W-1:0] clk_en_next;

  // Wakeup lines come from other domains and the pads
  assign wk_raw = {wk_irq, wk_low_voltage_detect, wk_central_timewheel, wk_rtc,
                   wk_i2c, wk_pin_interrupt_unit, wk_comparator};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      wk_s1_reg <= 7'h00;
      wk_s2_reg <= 7'h00;
    end else if (clk_en) begin
      wk_s1_reg <= wk_raw;
      wk_s2_reg <= wk_s1_reg;
    end
  end

  // Sleep accepts only its documented sources; hibernate only pins
  assign any_wake   = |wk_s2_reg;
  assign sleep_wake = |wk_s2_reg[5:0];
  assign hib_wake   = wk_s2_reg[1];

  always_comb begin
    mode_next       = mode_reg;
    resume_next     = resume_reg;
    resume_cnt_next = resume_cnt_reg;
    wake_evt        = 1'b0;
    case (mode_reg)
      PMC_MODE_ACTIVE, PMC_MODE_ALT_ACTIVE: begin
        wake_evt = any_wake;
        if (mode_req_we) begin
          case (mode_req)
            PMC_REQ_ALT:   mode_next = PMC_MODE_ALT_ACTIVE;
            PMC_REQ_SLEEP: mode_next = PMC_MODE_SLEEP;
            PMC_REQ_HIB:   mode_next = PMC_MODE_HIBERNATE;
            default:       mode_next = PMC_MODE_ACTIVE;
          endcase
        end
        // Wakeup in the same cycle overrides a mode write
        if (any_wake) begin
          mode_next = PMC_MODE_ACTIVE;
        end
      end
      PMC_MODE_SLEEP: begin
        if (resume_reg) begin
          if (resume_cnt_reg == RESUME_LAST) begin
            resume_next     = 1'b0;
            resume_cnt_next = '0;
            mode_next       = PMC_MODE_ACTIVE;
            wake_evt        = 1'b1;
          end else begin
            resume_cnt_next = resume_cnt_reg + PMC_CNT_W'(1);
          end
        end else if (sleep_wake) begin
          resume_next     = 1'b1;
          resume_cnt_next = '0;
        end
      end
      PMC_MODE_HIBERNATE: begin
        if (hib_wake) begin
          mode_next = PMC_MODE_ACTIVE;
          wake_evt  = 1'b1;
        end
      end
      default: mode_next = PMC_MODE_ACTIVE;
    endcase
  end

  // Halt request loses to a simultaneous wakeup
  assign cpu_off_next = wake_evt ? 1'b0 : (cpu_halt_req ? 1'b1 : cpu_off_reg);

  always_ff @(posedge sys_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      mode_reg       <= PMC_MODE_ACTIVE;
      resume_reg     <= 1'b0;
      resume_cnt_reg <= '0;
      cpu_off_reg    <= 1'b0;
    end else if (clk_en) begin
      mode_reg       <= mode_next;
      resume_reg     <= resume_next;
      resume_cnt_reg <= resume_cnt_next;
      cpu_off_reg    <= cpu_off_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      act_tpl_reg     <= PMC_ACT_TPL_RST;
      alt_tpl_reg     <= PMC_ALT_TPL_RST;
      ext_reg_off_reg <= 1'b0;
    end else if (clk_en) begin
      if (act_tpl_we) act_tpl_reg <= act_tpl_wdata;
      if (alt_tpl_we) alt_tpl_reg <= alt_tpl_wdata;
      if (reg_disable_we) ext_reg_off_reg <= reg_disable;
    end
  end

  // Template chosen by mode; low-power modes ignore templates
  always_comb begin
    case (mode_next)
      PMC_MODE_ACTIVE:     tpl_sel = act_tpl_reg;
      PMC_MODE_ALT_ACTIVE: tpl_sel = alt_tpl_reg;
      PMC_MODE_SLEEP:      tpl_sel = PMC_SLEEP_KEEP;
      default:             tpl_sel = '0;
    endcase
  end

  // CPU bit forced on at wakeup, else off if it halted itself
  always_comb begin
    clk_en_next = tpl_sel;
    if (cpu_off_next) clk_en_next[PMC_CPU_BIT] = 1'b0;
    if (wake_evt) clk_en_next[PMC_CPU_BIT] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      subsys_clk_en    <= PMC_ACT_TPL_RST;
      cpu_en           <= 1'b1;
      mode_out         <= 2'h0;
      sys_clk_run      <= 1'b1;
      slp_clk_sel      <= 2'h0;
      timewheel_rtc_en <= 1'b1;
      dig_reg_en       <= 1'b1;
      ana_reg_en       <= 1'b1;
      reg_buzz         <= 1'b0;
      hib_reg_en       <= 1'b1;
      resuming         <= 1'b0;
      act_tpl_rd       <= PMC_ACT_TPL_RST;
      alt_tpl_rd       <= PMC_ALT_TPL_RST;
    end else if (clk_en) begin
      subsys_clk_en    <= clk_en_next;
      cpu_en           <= clk_en_next[PMC_CPU_BIT];
      mode_out         <= mode_next;
      sys_clk_run      <= (mode_next == PMC_MODE_ACTIVE) ||
                          (mode_next == PMC_MODE_ALT_ACTIVE);
      slp_clk_sel      <= (mode_next == PMC_MODE_SLEEP) ?
                          (slp_clk_xtal_sel ? PMC_SLPCLK_XTAL : PMC_SLPCLK_LSO)
                          : 2'h0;
      timewheel_rtc_en <= (mode_next != PMC_MODE_HIBERNATE);
      dig_reg_en       <= (mode_next != PMC_MODE_HIBERNATE) && !ext_reg_off_reg;
      ana_reg_en       <= (mode_next != PMC_MODE_HIBERNATE) && !ext_reg_off_reg;
      reg_buzz         <= (mode_next == PMC_MODE_SLEEP) && !resume_next;
      hib_reg_en       <= 1'b1;
      resuming         <= resume_next;
      act_tpl_rd       <= act_tpl_reg;
      alt_tpl_rd       <= alt_tpl_reg;
    end
  end

  sequence s_sleep_wake;
    mode_reg == PMC_MODE_SLEEP && !resume_reg && sleep_wake && clk_en;
  endsequence

  AST_RESUME_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    s_sleep_wake |=> (mode_reg == PMC_MODE_SLEEP)[*8])
    else $error("Sleep left before resume interval");

  AST_RESUME_END: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (resume_reg && clk_en && resume_cnt_reg == RESUME_LAST) |=> mode_reg == PMC_MODE_ACTIVE)
    else $error("Resume did not reach active");

  AST_WAKE_ACTIVE: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (any_wake && clk_en && mode_reg != PMC_MODE_SLEEP && mode_reg != PMC_MODE_HIBERNATE)
    |=> (mode_reg == PMC_MODE_ACTIVE && cpu_en))
    else $error("Wakeup did not restore active with cpu");

  AST_HIB_PIN_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_HIBERNATE && !hib_wake && clk_en) |=> mode_reg == PMC_MODE_HIBERNATE)
    else $error("Hibernate left without pin wakeup");

  AST_HIB_GATED: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_HIBERNATE && mode_out == 2'h3)
    |-> (subsys_clk_en == '0 && !dig_reg_en && !ana_reg_en && hib_reg_en && !sys_clk_run))
    else $error("Hibernate outputs wrong");

  AST_NO_SELF_MOVE: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_ACTIVE && !mode_req_we && clk_en) |=> mode_reg == PMC_MODE_ACTIVE)
    else $error("Mode changed without write");

  AST_ACT_TPL: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_ACTIVE && mode_next == PMC_MODE_ACTIVE && clk_en && !act_tpl_we)
    |=> subsys_clk_en[PMC_SUBSYS_W-1:1] == act_tpl_reg[PMC_SUBSYS_W-1:1])
    else $error("Active clock enables differ from template");

  AST_CPU_HALT: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (cpu_halt_req && !wake_evt && clk_en) |=> !cpu_en)
    else $error("CPU halt ignored");

  AST_SLEEP_CLK: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_SLEEP && $stable(mode_reg) && mode_out == 2'h2)
    |-> (slp_clk_sel != 2'h0 && timewheel_rtc_en && !sys_clk_run))
    else $error("Sleep clocking wrong");

  AST_ALT_TPL: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_ALT_ACTIVE && mode_next == PMC_MODE_ALT_ACTIVE &&
     clk_en && !alt_tpl_we)
    |=> subsys_clk_en[PMC_SUBSYS_W-1:1] == alt_tpl_reg[PMC_SUBSYS_W-1:1])
    else $error("Alt clock enables differ from template");

  AST_SLEEP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (mode_reg == PMC_MODE_SLEEP && !resume_reg && !sleep_wake && clk_en)
    |=> (mode_reg == PMC_MODE_SLEEP && !resume_reg))
    else $error("Sleep left without its wakeup sources");

  AST_REG_OFF: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    (ext_reg_off_reg && clk_en) |=> (!dig_reg_en && !ana_reg_en))
    else $error("Internal regulators on after disable");

  sequence s_hib_pin_wake;
    mode_reg == PMC_MODE_HIBERNATE && hib_wake && clk_en;
  endsequence

  AST_HIB_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    s_hib_pin_wake |=> (mode_reg == PMC_MODE_ACTIVE && cpu_en && sys_clk_run))
    else $error("Pin wakeup did not leave hibernate");

  // Outputs must freeze too, or gated clock enables could glitch
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_s2_reg)
    !clk_en |=> ($stable(mode_reg) && $stable(subsys_clk_en) && $stable(resume_cnt_reg)))
    else $error("State moved while clock enable low");

endmodule // pmc_top

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import pmc_pkg::*;
;
  logic                    sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic [PMC_SUBSYS_W-1:0] act_d = 8'h00, alt_d = 8'h00, sub, act_rd, alt_rd;
  logic                    act_we = 1'b0, alt_we = 1'b0, m_we = 1'b0, halt = 1'b0;
  logic [1:0]              m_req = 2'h0, mode, sclk;
  logic                    xtal = 1'b0, rdis = 1'b0, rdis_we = 1'b0;
  logic [6:0]              wk = 7'h00;
  logic                    cpu, run, twr, dreg, areg, buzz, hreg, resm;
  int                      failures = 0, checked = 0;

  pmc_top pmc_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .act_tpl_wdata(act_d), .act_tpl_we(act_we), .alt_tpl_wdata(alt_d), .alt_tpl_we(alt_we),
    .mode_req(m_req), .mode_req_we(m_we), .cpu_halt_req(halt), .slp_clk_xtal_sel(xtal),
    .reg_disable(rdis), .reg_disable_we(rdis_we), .wk_comparator(wk[0]),
    .wk_pin_interrupt_unit(wk[1]), .wk_i2c(wk[2]), .wk_rtc(wk[3]),
    .wk_central_timewheel(wk[4]), .wk_low_voltage_detect(wk[5]), .wk_irq(wk[6]),
    .subsys_clk_en(sub), .cpu_en(cpu), .mode_out(mode), .sys_clk_run(run),
    .slp_clk_sel(sclk), .timewheel_rtc_en(twr), .dig_reg_en(dreg), .ana_reg_en(areg),
    .reg_buzz(buzz), .hib_reg_en(hreg), .resuming(resm), .act_tpl_rd(act_rd),
    .alt_tpl_rd(alt_rd));

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(mode === 2'h0 && sub === 8'hff && cpu === 1'b1 && run === 1'b1, "reset mode");
    chk(dreg === 1'b1 && areg === 1'b1 && hreg === 1'b1 && sclk === 2'h0, "reset regs");
    chk(act_rd === PMC_ACT_TPL_RST && alt_rd === PMC_ALT_TPL_RST, "reset templates");
  endtask

  // One-cycle strobes plus a spare edge: outputs lag the stored value by one
  task automatic wr_act(input logic [7:0] d);
    act_d = d;
    act_we = 1'b1;
    @(negedge sys_clk);
    act_we = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic req(input logic [1:0] m);
    m_req = m;
    m_we = 1'b1;
    @(negedge sys_clk);
    m_we = 1'b0;
    @(negedge sys_clk);
  endtask

  // Wake line passes two sync flops, acted on at the third edge
  task automatic wake(input int b);
    wk[b] = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic unwake(input int b);
    wk[b] = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic t_active();
    wr_act(8'h5a);
    chk(sub === 8'h5a && cpu === 1'b0, "active gating");
    wr_act(8'ha5);
    chk(sub === 8'ha5 && act_rd === 8'ha5, "dynamic template");
    halt = 1'b1;
    @(negedge sys_clk);
    halt = 1'b0;
    chk(cpu === 1'b0 && sub === 8'ha4, "cpu halt");
    wake(6);
    chk(cpu === 1'b1 && sub === 8'ha5 && mode === 2'h0, "wake cpu");
    unwake(6);
    wr_act(8'hff);
  endtask

  task automatic t_alt();
    alt_d = 8'h3c;
    alt_we = 1'b1;
    @(negedge sys_clk);
    alt_we = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(mode === 2'h0 && sub === 8'hff, "no mode change without write");
    req(PMC_REQ_ALT);
    chk(mode === PMC_REQ_ALT && sub === 8'h3c && run === 1'b1, "alt template");
    req(2'h0);
    chk(mode === 2'h0 && sub === 8'hff && cpu === 1'b1, "alt to active by write");
    clk_en = 1'b0;
    req(PMC_REQ_ALT);
    chk(mode === 2'h0 && sub === 8'hff, "frozen by clock enable");
    clk_en = 1'b1;
    req(PMC_REQ_ALT);
    chk(mode === PMC_REQ_ALT && sub === 8'h3c, "alt again");
    wake(6);
    chk(mode === 2'h0 && cpu === 1'b1 && sub === 8'hff, "alt wake");
    unwake(6);
  endtask

  task automatic t_sleep(input int b);
    xtal = b[0];
    req(PMC_REQ_SLEEP);
    chk(mode === PMC_REQ_SLEEP && sub === 8'h00 && run === 1'b0, "sleep off");
    chk(buzz === 1'b1 && twr === 1'b1, "sleep buzz");
    chk(sclk === (b[0] ? PMC_SLPCLK_XTAL : PMC_SLPCLK_LSO), "sleep clock");
    req(PMC_REQ_HIB);
    wake(6);
    chk(mode === PMC_REQ_SLEEP && resm === 1'b0, "sleep refuses");
    unwake(6);
    wake(b);
    chk(resm === 1'b1 && buzz === 1'b0, "resume start");
    repeat (PMC_RESUME_CYC - 1) @(negedge sys_clk);
    chk(resm === 1'b1 && mode === PMC_REQ_SLEEP, "resume early");
    @(negedge sys_clk);
    chk(resm === 1'b0 && mode === 2'h0 && cpu === 1'b1 && run === 1'b1, "resume end");
    unwake(b);
  endtask

  task automatic t_hib();
    req(PMC_REQ_HIB);
    chk(mode === PMC_REQ_HIB && run === 1'b0 && twr === 1'b0 && sub === 8'h00, "hib");
    chk(dreg === 1'b0 && areg === 1'b0 && hreg === 1'b1, "hib regs");
    wr_act(8'h0e);
    for (int b = 0; b < 7; b++) begin
      if (b != 1) begin
        wake(b);
        chk(mode === PMC_REQ_HIB, "hib refuses");
        unwake(b);
      end
    end
    wake(1);
    chk(mode === 2'h0 && sub === 8'h0f && act_rd === 8'h0e, "hib pin wake");
    unwake(1);
  endtask

  task automatic t_reg();
    rdis = 1'b1;
    rdis_we = 1'b1;
    @(negedge sys_clk);
    rdis_we = 1'b0;
    @(negedge sys_clk);
    chk(dreg === 1'b0 && areg === 1'b0, "reg disable");
    do_reset();
  endtask

  initial begin
    do_reset();
    t_active();
    t_alt();
    for (int b = 0; b < 6; b++) t_sleep(b);
    t_hib();
    t_reg();
    end_sim();
  end

  // Roughly twice the expected run length
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule // tb_top
